// ===== scr_cfg.svh
// constants of the serial control block: register map, field positions,
// reset values and timing counts; included by scr_ctrl, its checker, the clock tick generator and the bench
`ifndef SCR_CFG_SVH
`define SCR_CFG_SVH

// register byte offsets on the avalon slave
`define SCR_ADDR_CTRL 5'h00
`define SCR_ADDR_STAT 5'h04
`define SCR_ADDR_DATA 5'h08
`define SCR_ADDR_EVT 5'h0C
`define SCR_ADDR_MASK 5'h10

// control register fields
`define SCR_CTL_RIE 7
`define SCR_CTL_EN 6
`define SCR_CTL_TIE 5
`define SCR_CTL_MS 4
`define SCR_CTL_POL 3
`define SCR_CTL_PHA 2
`define SCR_CTL_RESET 8'h04

// serial status fields
`define SCR_STAT_DONE 7
`define SCR_STAT_TXE 5
`define SCR_STAT_FAULT 4

// event status and mask fields
`define SCR_EVT_DONE 0
`define SCR_EVT_FAULT 1
`define SCR_EVT_TXE 2
`define SCR_EVT_RESET 3'h0
`define SCR_MASK_RESET 3'h0

// clock cycles per half serial clock period in master mode
`define SCR_HALF_DIV 3'h4
// serial clock edges in one byte
`define SCR_EDGES 5'h10

`endif

// ===== scr_ctrl.sv
// serial peripheral control block: avalon-mm register slave, control
// register side effects, byte transfer engine for master and slave, interrupt
// assumes an avalon master on clk_sys and serial pins asynchronous to it
`include "scr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
// Function
// - receive enable requests interrupt while transfer-complete or mode-fault flag set.
// - system enable activates interface and gives it the pins; clear disables.
// - clearing system enable forces idle and resets all status flags.
// - transmit enable requests interrupt while transmit-empty flag is set.
// - master select zero means slave mode, one means master mode.
// - any change of master select forces the interface idle.
// - polarity zero idles clock low, one idles clock high.
// - both link ends must use the same clock polarity.
// - phase zero samples on odd clock edges, one on even edges.
// - in master mode a polarity or phase change aborts the transfer.
module scr_ctrl (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // interrupt
    output logic irq,
    // serial pins
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    input wire logic ss_b_in,
    // pin ownership
    output logic pins_active
);
    logic [7:0] ctl_reg;
    logic [7:0] ctl_next;
    logic [7:0] tx_buf_reg;
    logic [7:0] rx_reg;
    logic [7:0] shift_reg;
    logic [4:0] cnt_reg;
    logic [4:0] edge_num;
    logic [2:0] evt_reg;
    logic [2:0] mask_reg;
    logic [2:0] evt_set;
    logic [31:0] rd_mux;
    logic [3:0] sync_out;
    logic tx_full_reg;
    logic done_reg;
    logic fault_reg;
    logic txe_prev_reg;
    logic in_bit_reg;
    logic sck_reg;
    logic sck_prev_reg;
    logic sck_s;
    logic mosi_s;
    logic miso_s;
    logic ss_s;
    logic acc;
    logic acc_rd;
    logic acc_wr;
    logic wr_ctl;
    logic wr_lane;
    logic en;
    logic master;
    logic abort;
    logic fault_evt;
    logic tick;
    logic slave_edge;
    logic step;
    logic din;
    logic sample_edge;
    logic shift_edge;
    logic last_edge;
    logic done_evt;
    logic take;
    logic rule_req;
    scr_pkg::scr_state_t state_reg;

    // pins into the clk_sys domain
    scr_sync #(
        .W(4)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .async_in({ss_b_in, miso_in, mosi_in, sck_in}),
        .sync_out(sync_out)
    );

    assign sck_s = sync_out[0];
    assign mosi_s = sync_out[1];
    assign miso_s = sync_out[2];
    assign ss_s = sync_out[3];

    // master serial clock ticks
    scr_sckgen u_sckgen (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .run(state_reg == scr_pkg::SCR_BUSY && master && !abort),
        .tick(tick)
    );

    // bus access: one wait cycle, then the request is taken
    assign acc = (avs_read || avs_write) && !avs_waitrequest;
    assign acc_rd = acc && avs_read;
    assign acc_wr = acc && avs_write;
    assign wr_lane = acc_wr && avs_byteenable[0];
    assign wr_ctl = wr_lane && avs_address == `SCR_ADDR_CTRL;
    assign ctl_next = wr_ctl ? avs_writedata[7:0] : ctl_reg;

    assign en = ctl_reg[`SCR_CTL_EN];
    assign master = ctl_reg[`SCR_CTL_MS];

    // mode fault: another master pulls select low while this end is master
    assign fault_evt = en && master && !ss_s;

    // abort on disable, mode fault, master select change, master polarity or phase change, or slave deselect
    always_comb begin
        abort = !en || fault_evt;
        if (ctl_next[`SCR_CTL_MS] != ctl_reg[`SCR_CTL_MS]) begin
            abort = 1'b1;
        end
        if (master && (ctl_next[`SCR_CTL_POL] != ctl_reg[`SCR_CTL_POL] ||
                ctl_next[`SCR_CTL_PHA] != ctl_reg[`SCR_CTL_PHA])) begin
            abort = 1'b1;
        end
        if (!master && ss_s) begin
            abort = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            avs_waitrequest <= 1'b1;
        end else if (acc) begin
            avs_waitrequest <= 1'b1;
        end else if (avs_read || avs_write) begin
            avs_waitrequest <= 1'b0;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            `SCR_ADDR_CTRL: begin
                rd_mux[7:0] = ctl_reg;
            end
            `SCR_ADDR_STAT: begin
                rd_mux[`SCR_STAT_DONE] = done_reg;
                rd_mux[`SCR_STAT_TXE] = !tx_full_reg;
                rd_mux[`SCR_STAT_FAULT] = fault_reg;
            end
            `SCR_ADDR_DATA: begin
                rd_mux[7:0] = rx_reg;
            end
            `SCR_ADDR_EVT: begin
                rd_mux[2:0] = evt_reg;
            end
            `SCR_ADDR_MASK: begin
                rd_mux[2:0] = mask_reg;
            end
            default: begin
                rd_mux = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= rd_mux;
        end
    end

    // writable registers
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ctl_reg <= `SCR_CTL_RESET;
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            mask_reg <= `SCR_MASK_RESET;
        end else if (wr_lane && avs_address == `SCR_ADDR_MASK) begin
            mask_reg <= avs_writedata[2:0];
        end
    end

    // transmit buffer: written only while empty
    assign take = state_reg == scr_pkg::SCR_IDLE && tx_full_reg && (master ? !abort : (ss_s && en));

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            tx_buf_reg <= 8'h00;
        end else if (wr_lane && avs_address == `SCR_ADDR_DATA && !tx_full_reg) begin
            tx_buf_reg <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            tx_full_reg <= 1'b0;
        end else if (!en) begin
            tx_full_reg <= 1'b0;
        end else if (take) begin
            tx_full_reg <= 1'b0;
        end else if (wr_lane && avs_address == `SCR_ADDR_DATA) begin
            tx_full_reg <= 1'b1;
        end
    end

    // completion flag: set wins over the clearing data read
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            done_reg <= 1'b0;
        end else if (!en) begin
            done_reg <= 1'b0;
        end else if (done_evt) begin
            done_reg <= 1'b1;
        end else if (acc_rd && avs_address == `SCR_ADDR_DATA) begin
            done_reg <= 1'b0;
        end
    end

    // mode fault flag: cleared by a control write, set wins
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            fault_reg <= 1'b0;
        end else if (!en) begin
            fault_reg <= 1'b0;
        end else if (fault_evt) begin
            fault_reg <= 1'b1;
        end else if (wr_ctl) begin
            fault_reg <= 1'b0;
        end
    end

    // slave clock edges from the synchronised pin
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sck_prev_reg <= 1'b0;
        end else begin
            sck_prev_reg <= sck_s;
        end
    end

    assign slave_edge = sck_s ^ sck_prev_reg;
    assign step = master ? tick : slave_edge;
    assign din = master ? miso_s : mosi_s;
    assign edge_num = cnt_reg + 5'h01;
    assign sample_edge = ctl_reg[`SCR_CTL_PHA] ? !edge_num[0] : edge_num[0];
    assign last_edge = edge_num == `SCR_EDGES;
    assign shift_edge = ctl_reg[`SCR_CTL_PHA] ? (edge_num[0] && edge_num != 5'h01) : (!edge_num[0] && !last_edge);
    assign done_evt = state_reg == scr_pkg::SCR_BUSY && step && last_edge && !abort;

    // byte transfer engine, shared by master and slave
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_reg <= scr_pkg::SCR_IDLE;
            cnt_reg <= 5'h00;
            shift_reg <= 8'h00;
            in_bit_reg <= 1'b0;
            rx_reg <= 8'h00;
            sck_reg <= 1'b0;
        end else if (abort) begin
            state_reg <= scr_pkg::SCR_IDLE;
            cnt_reg <= 5'h00;
            sck_reg <= ctl_next[`SCR_CTL_POL];
            if (take) begin
                shift_reg <= tx_buf_reg;
            end
        end else begin
            case (state_reg)
                scr_pkg::SCR_IDLE: begin
                    cnt_reg <= 5'h00;
                    sck_reg <= ctl_reg[`SCR_CTL_POL];
                    if (take) begin
                        shift_reg <= tx_buf_reg;
                    end
                    if (master ? tx_full_reg : !ss_s) begin
                        state_reg <= scr_pkg::SCR_BUSY;
                    end
                end
                scr_pkg::SCR_BUSY: begin
                    if (step) begin
                        cnt_reg <= edge_num;
                        sck_reg <= ctl_reg[`SCR_CTL_POL] ^ edge_num[0];
                        if (sample_edge) begin
                            in_bit_reg <= din;
                        end
                        if (shift_edge) begin
                            shift_reg <= {shift_reg[6:0], in_bit_reg};
                        end
                        if (last_edge) begin
                            rx_reg <= {shift_reg[6:0], ctl_reg[`SCR_CTL_PHA] ? din : in_bit_reg};
                            state_reg <= scr_pkg::SCR_IDLE;
                        end
                    end
                end
                default: begin
                    state_reg <= scr_pkg::SCR_IDLE;
                end
            endcase
        end
    end

    // pin drivers
    // pins owned only while enabled
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sck_out <= 1'b0;
            sck_oe <= 1'b0;
            mosi_out <= 1'b0;
            mosi_oe <= 1'b0;
            miso_out <= 1'b0;
            miso_oe <= 1'b0;
            pins_active <= 1'b0;
        end else begin
            sck_out <= sck_reg;
            sck_oe <= en && master;
            mosi_out <= shift_reg[7];
            mosi_oe <= en && master;
            miso_out <= shift_reg[7];
            miso_oe <= en && !master && !ss_s;
            pins_active <= en;
        end
    end

    // sticky events, cleared by reading them; set wins over clear
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            txe_prev_reg <= 1'b1;
        end else begin
            txe_prev_reg <= !tx_full_reg;
        end
    end

    assign evt_set[`SCR_EVT_DONE] = done_evt;
    assign evt_set[`SCR_EVT_FAULT] = fault_evt && !fault_reg;
    assign evt_set[`SCR_EVT_TXE] = !tx_full_reg && !txe_prev_reg;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            evt_reg <= `SCR_EVT_RESET;
        end else if (acc_rd && avs_address == `SCR_ADDR_EVT) begin
            evt_reg <= (evt_reg & ~avs_readdata[2:0]) | evt_set;
        end else begin
            evt_reg <= evt_reg | evt_set;
        end
    end

    assign rule_req = (ctl_reg[`SCR_CTL_RIE] && (done_reg || fault_reg)) ||
        (ctl_reg[`SCR_CTL_TIE] && !tx_full_reg);

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= rule_req || (|(evt_reg & mask_reg));
        end
    end
endmodule
`default_nettype wire

// ===== scr_ctrl_props.sv
// checker of the serial control block, bound to every scr_ctrl
// assumes one clk_sys domain with synchronous active-low rst_b
`include "scr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module scr_ctrl_props (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // interrupt and pins
    input wire logic irq,
    input wire logic sck_out,
    input wire logic sck_oe,
    input wire logic mosi_oe,
    input wire logic miso_oe,
    input wire logic pins_active
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    logic [7:0] ctl_reg;
    logic [2:0] msk_reg;
    wire logic rd_take = avs_read && !avs_waitrequest;
    wire logic wr_ctl = avs_write && !avs_waitrequest && avs_address == `SCR_ADDR_CTRL && avs_byteenable[0];
    wire logic wr_msk = avs_write && !avs_waitrequest && avs_address == `SCR_ADDR_MASK && avs_byteenable[0];
    // mirror of what software wrote
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ctl_reg <= `SCR_CTL_RESET;
            msk_reg <= `SCR_MASK_RESET;
        end else begin
            if (wr_ctl)
                ctl_reg <= avs_writedata[7:0];
            if (wr_msk)
                msk_reg <= avs_writedata[2:0];
        end
    end
    sequence s_one_wait;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    sequence s_sck_idle;
        (sck_out == ctl_reg[`SCR_CTL_POL]) [*4];
    endsequence
    AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> s_one_wait)
        else $error("waitrequest not low for exactly one cycle");
    AST_NO_SPURIOUS: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest dropped without request");
    AST_CTRL_READBACK: assert property (rd_take && avs_address == `SCR_ADDR_CTRL |-> avs_readdata == {24'h0, ctl_reg})
        else $error("control read back differs from written value");
    AST_PINS: assert property (pins_active == $past(ctl_reg[`SCR_CTL_EN]))
        else $error("pins_active does not follow enable");
    AST_MASTER_OE: assert property ((sck_oe || mosi_oe) |-> $past(ctl_reg[`SCR_CTL_EN] && ctl_reg[`SCR_CTL_MS]))
        else $error("master pins driven outside enabled master mode");
    AST_SLAVE_OE: assert property (miso_oe |-> $past(ctl_reg[`SCR_CTL_EN] && !ctl_reg[`SCR_CTL_MS]))
        else $error("slave output driven outside enabled slave mode");
    AST_IRQ_SRC: assert property (irq |-> $past(ctl_reg[`SCR_CTL_RIE] || ctl_reg[`SCR_CTL_TIE] || (|msk_reg)))
        else $error("irq high with every source disabled");
    AST_ABORT_IDLE: assert property (wr_ctl && ctl_reg[`SCR_CTL_EN] && ctl_reg[`SCR_CTL_MS] && avs_writedata[`SCR_CTL_EN]
        && avs_writedata[`SCR_CTL_MS] && avs_writedata[`SCR_CTL_POL] != ctl_reg[`SCR_CTL_POL] |-> ##3 s_sck_idle)
        else $error("polarity change did not idle the serial clock");
    AST_DIS_STATUS: assert property (rd_take && avs_address == `SCR_ADDR_STAT && !$past(ctl_reg[`SCR_CTL_EN], 2)
        |-> (avs_readdata[7:0] & 8'hB0) == 8'h20)
        else $error("status flags not reset while disabled");
endmodule
bind scr_ctrl scr_ctrl_props u_props (.clk_sys, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .irq, .sck_out, .sck_oe, .mosi_oe, .miso_oe, .pins_active);
`default_nettype wire

// ===== scr_far_slave.sv
// far-side serial slave model: shifts a byte out and in while selected
// assumes sck stands at its idle level when sel rises
`timescale 1ns/1ps
`default_nettype none
module scr_far_slave (
    // selection and format
    input wire logic sel,
    input wire logic pha,
    input wire logic [7:0] tx_byte,
    // serial lines
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    output logic [7:0] rx_byte
);
    int edge_n = 0;
    int bit_n = 0;
    initial miso = 1'b0;
    initial rx_byte = 8'h00;
    always @(posedge sel) begin
        edge_n = 0;
        bit_n = pha ? 0 : 1;
        if (!pha)
            miso = tx_byte[7];
    end
    // released line shows the inverse of its last value
    always @(negedge sel) miso = ~miso;
    always @(sck) if (sel) begin
        edge_n++;
        if (edge_n[0] != pha)
            rx_byte = {rx_byte[6:0], mosi};
        else if (bit_n < 8) begin
            miso = tx_byte[7 - bit_n];
            bit_n++;
        end
    end
endmodule
`default_nettype wire

// ===== scr_pkg.sv
// types shared by the serial control block modules
// assumes scr_cfg.svh is found on the include path
package scr_pkg;
    // transfer engine states
    typedef enum logic {
        SCR_IDLE,
        SCR_BUSY
    } scr_state_t;
endpackage

// ===== scr_sckgen.sv
// serial clock edge ticks for master mode, one pulse per half period
// assumes run is driven from logic on clk_sys
`include "scr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module scr_sckgen (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // control and tick
    input wire logic run,
    output logic tick
);
    logic [2:0] div_reg;

    // count restarts whenever run drops, so the first edge comes a full half period late
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            div_reg <= 3'h0;
            tick <= 1'b0;
        end else if (!run) begin
            div_reg <= 3'h0;
            tick <= 1'b0;
        end else if (div_reg == `SCR_HALF_DIV - 3'h1) begin
            div_reg <= 3'h0;
            tick <= 1'b1;
        end else begin
            div_reg <= div_reg + 3'h1;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== scr_sync.sv
// two-flop synchroniser, one per bit, for pins from outside the clk_sys domain
// assumes the inputs change asynchronously to clk_sys
`timescale 1ns/1ps
`default_nettype none
module scr_sync #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // asynchronous and synchronised levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always_ff @(posedge clk_sys) begin
                if (!rst_b) begin
                    meta_reg[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta_reg[i] <= async_in[i];
                    sync_out[i] <= meta_reg[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ===== spi_control_register_one_bench.sv
// self-checking bench of scr_ctrl with a far serial slave model
// assumes scr_cfg.svh on the include path and the bound checker
`include "scr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module spi_control_register_one_bench;
    typedef struct {logic [4:0] a; logic [31:0] e; logic [31:0] m;} scr_note_t;
    logic clk_sys, rst_b, avs_read, avs_write, ss_b, far_sel, far_pha, mosi_far;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [7:0] far_tx, far_rx;
    logic avs_waitrequest, irq, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, pins_active, miso_far;
    wire logic sck_w = sck_oe ? sck_out : 1'b0;
    wire logic mosi_w = mosi_oe ? mosi_out : mosi_far;
    wire logic miso_w = miso_oe ? miso_out : miso_far;
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;
    scr_note_t notes[$];
    scr_note_t nt;
    scr_ctrl u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .sck_in(sck_w),
        .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
        .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe), .ss_b_in(ss_b), .pins_active(pins_active));
    scr_far_slave u_far (.sel(far_sel), .pha(far_pha), .tx_byte(far_tx), .sck(sck_w), .mosi(mosi_w),
        .miso(miso_far), .rx_byte(far_rx));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic conclude;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk_rd(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] be);
        @(posedge clk_sys);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back('{a, e, m});
        bus(1'b0, a, 8'h00, 4'hF);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wait_irq(input int lim);
        for (int i = 0; i < lim && irq !== 1'b1; i++) @(posedge clk_sys);
        chk_bit("irq", 1'b1, irq);
    endtask
    // read results checked as they are taken
    always @(posedge clk_sys) if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && notes.size() > 0) begin
        nt = notes.pop_front();
        chk_rd($sformatf("read %h", nt.a), nt.e, avs_readdata & nt.m);
    end
    always @(posedge clk_sys) mosi_far <= ~mosi_far;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            $display("[ERR] run limit expected end seen hang");
            conclude();
        end
    end
    initial begin
        logic [7:0] tx;
        {rst_b, avs_read, avs_write, far_sel, far_pha, mosi_far} = 6'h00;
        {avs_address, avs_writedata, far_tx} = 45'h0;
        avs_byteenable = 4'hF;
        ss_b = 1'b1;
        void'($urandom(62269));
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        chk_bit("irq", 1'b0, irq);
        rd(`SCR_ADDR_CTRL, 32'h04, 32'hFFFFFFFF);
        rd(`SCR_ADDR_STAT, 32'h20, 32'hB0);
        rd(`SCR_ADDR_MASK, 32'h0, 32'hFFFFFFFF);
        rd(5'h14, 32'h0, 32'hFFFFFFFF);
        bus(1'b1, `SCR_ADDR_CTRL, 8'hFF, 4'h0);
        rd(`SCR_ADDR_CTRL, 32'h04, 32'hFF);
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            tx = 8'($urandom);
            far_tx <= 8'($urandom);
            far_pha <= m[0];
            wr(`SCR_ADDR_CTRL, {4'hD, m[1], m[0], 2'h0});
            tick(3);
            chk_bit("sck idle", m[1], sck_out);
            chk_bit("pins_active", 1'b1, pins_active);
            chk_bit("mosi_oe", 1'b1, mosi_oe);
            far_sel <= 1'b1;
            wr(`SCR_ADDR_DATA, tx);
            wait_irq(300);
            rd(`SCR_ADDR_STAT, 32'h80, 32'h90);
            rd(`SCR_ADDR_DATA, {24'h0, far_tx}, 32'hFF);
            chk_rd("far rx", {24'h0, tx}, {24'h0, far_rx});
            far_sel <= 1'b0;
            rd(`SCR_ADDR_STAT, 32'h0, 32'h80);
            tick(3);
            chk_bit("irq", 1'b0, irq);
        end
        $display("test transfers done");
        wr(`SCR_ADDR_CTRL, 8'h70);
        tick(3);
        chk_bit("irq", 1'b1, irq);
        wr(`SCR_ADDR_CTRL, 8'h50);
        tick(3);
        chk_bit("irq", 1'b0, irq);
        rd(`SCR_ADDR_EVT, 32'h05, 32'h05);
        rd(`SCR_ADDR_EVT, 32'h0, 32'h07);
        wr(`SCR_ADDR_MASK, 8'h04);
        wr(`SCR_ADDR_DATA, 8'($urandom));
        wait_irq(50);
        rd(`SCR_ADDR_EVT, 32'h04, 32'h04);
        tick(3);
        chk_bit("irq", 1'b0, irq);
        wr(`SCR_ADDR_MASK, 8'h00);
        tick(100);
        rd(`SCR_ADDR_STAT, 32'h80, 32'h80);
        bus(1'b0, `SCR_ADDR_DATA, 8'h00, 4'hF);
        $display("test interrupts done");
        wr(`SCR_ADDR_DATA, 8'($urandom));
        tick(20);
        wr(`SCR_ADDR_CTRL, 8'h58);
        tick(4);
        chk_bit("sck idle", 1'b1, sck_out);
        tick(120);
        rd(`SCR_ADDR_STAT, 32'h20, 32'hA0);
        wr(`SCR_ADDR_DATA, 8'($urandom));
        tick(20);
        wr(`SCR_ADDR_CTRL, 8'h48);
        tick(120);
        rd(`SCR_ADDR_STAT, 32'h0, 32'h80);
        chk_bit("sck_oe", 1'b0, sck_oe);
        tx = 8'($urandom);
        wr(`SCR_ADDR_DATA, tx);
        tick(3);
        ss_b <= 1'b0;
        tick(6);
        chk_bit("miso_oe", 1'b1, miso_oe);
        chk_bit("miso_out", tx[7], miso_out);
        ss_b <= 1'b1;
        tick(6);
        chk_bit("miso_oe", 1'b0, miso_oe);
        $display("test abort and modes done");
        wr(`SCR_ADDR_CTRL, 8'hD0);
        ss_b <= 1'b0;
        tick(8);
        chk_bit("irq", 1'b1, irq);
        rd(`SCR_ADDR_STAT, 32'h10, 32'h10);
        ss_b <= 1'b1;
        tick(4);
        wr(`SCR_ADDR_CTRL, 8'h50);
        wr(`SCR_ADDR_DATA, 8'($urandom));
        tick(120);
        rd(`SCR_ADDR_STAT, 32'h80, 32'h90);
        wr(`SCR_ADDR_CTRL, 8'h10);
        tick(2);
        rd(`SCR_ADDR_STAT, 32'h20, 32'hB0);
        chk_bit("pins_active", 1'b0, pins_active);
        $display("test fault and disable done");
        conclude();
    end
endmodule
`default_nettype wire
